// [rtl/sltw_pkg.sv]
// Constants and types of the second-level table walk
`default_nettype none

package sltw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor type codes
    localparam logic [1:0] L1_INVALID = 2'h0;
    localparam logic [1:0] L1_COARSE = 2'h1;
    localparam logic [1:0] L1_SECTION = 2'h2;
    localparam logic [1:0] L1_FINE = 2'h3;

    // Field positions
    localparam int TYPE_HI = 1;
    localparam int TYPE_LO = 0;
    localparam int DOM_HI = 8;
    localparam int DOM_LO = 5;
    localparam int CB_HI = 3;
    localparam int CB_LO = 2;
    localparam int PERM_HI = 11;
    localparam int PERM_LO = 4;
    localparam int TINY_PERM_HI = 5;
    localparam int TINY_PERM_LO = 4;
    localparam int TTB_LO = 14;
    localparam int L1_IDX_LO = 20;
    localparam int COARSE_BASE_LO = 10;
    localparam int FINE_BASE_LO = 12;
    localparam int COARSE_IDX_LO = 12;
    localparam int FINE_IDX_LO = 10;
    localparam int L2_IDX_HI = 19;
    localparam int LARGE_BASE_LO = 16;
    localparam int SMALL_BASE_LO = 12;
    localparam int TINY_BASE_LO = 10;

    // Reset values
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [3:0] DOM_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        SLTW_IDLE = 3'h1,
        SLTW_L1 = 3'h2,
        SLTW_L2 = 3'h4
    } sltw_state_t;

    // Encodings match descriptor bits 3:2 (C, B)
    typedef enum logic [1:0] {
        SLTW_NC_NB = 2'h0,
        SLTW_NC_B = 2'h1,
        SLTW_WT = 2'h2,
        SLTW_WB = 2'h3
    } sltw_policy_t;

    // Encodings match second-level type bits
    typedef enum logic [1:0] {
        SLTW_SZ_NONE = 2'h0,
        SLTW_SZ_LARGE = 2'h1,
        SLTW_SZ_SMALL = 2'h2,
        SLTW_SZ_TINY = 2'h3
    } sltw_size_t;

    typedef struct packed {
        logic [31:0] phys_addr;
        logic [7:0] access_permission_field;
        sltw_policy_t policy;
        logic [3:0] domain;
        sltw_size_t size;
        logic section_desc;
        logic section_fault;
        logic page_fault;
    } sltw_result_t;

endpackage : sltw_pkg

`default_nettype wire

// [rtl/sltw_walk.sv]
// Table walk engine: first-level fetch, coarse/fine second-level fetch and page decode
`timescale 1ns/10ps
`default_nettype none

module sltw_walk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic WALK_REQ,
    input wire logic [31:0] MODIFIED_VIRTUAL_ADDRESS,
    input wire logic [31:0] TRANSLATION_TABLE_BASE,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    output logic WALK_BUSY,
    output logic MEM_REQ,
    output logic [31:0] MEM_ADDR,
    output logic WALK_DONE,
    output sltw_pkg::sltw_result_t WALK_RESULT
);

    ////////////////////////////////////////////////////////////////////////////
    // Second-level decode
    function automatic sltw_pkg::sltw_result_t l2_decode(
        input logic [31:0] desc,
        input logic [31:0] va,
        input logic [3:0] dom
    );
        sltw_pkg::sltw_result_t r;
        r = '0;
        r.domain = dom;
        r.size = sltw_pkg::sltw_size_t'(desc[sltw_pkg::TYPE_HI:sltw_pkg::TYPE_LO]);
        r.policy = sltw_pkg::sltw_policy_t'(desc[sltw_pkg::CB_HI:sltw_pkg::CB_LO]);
        case (desc[sltw_pkg::TYPE_HI:sltw_pkg::TYPE_LO])
            sltw_pkg::SLTW_SZ_LARGE: begin
                r.phys_addr = {desc[31:sltw_pkg::LARGE_BASE_LO], va[sltw_pkg::LARGE_BASE_LO-1:0]};
                r.access_permission_field = desc[sltw_pkg::PERM_HI:sltw_pkg::PERM_LO];
            end
            sltw_pkg::SLTW_SZ_SMALL: begin
                r.phys_addr = {desc[31:sltw_pkg::SMALL_BASE_LO], va[sltw_pkg::SMALL_BASE_LO-1:0]};
                r.access_permission_field = desc[sltw_pkg::PERM_HI:sltw_pkg::PERM_LO];
            end
            sltw_pkg::SLTW_SZ_TINY: begin
                r.phys_addr = {desc[31:sltw_pkg::TINY_BASE_LO], va[sltw_pkg::TINY_BASE_LO-1:0]};
                // One set copied to every subpage slot, so the whole page shares it
                r.access_permission_field = {4{desc[sltw_pkg::TINY_PERM_HI:sltw_pkg::TINY_PERM_LO]}};
            end
            default: begin
                r.page_fault = 1'b1;
                r.policy = sltw_pkg::SLTW_NC_NB;
            end
        endcase
        return r;
    endfunction : l2_decode

    ////////////////////////////////////////////////////////////////////////////
    // State
    sltw_pkg::sltw_state_t state_q;
    logic [31:0] va_q;
    logic [31:0] l1_desc_q;
    logic [31:0] l2_addr_d;
    logic l1_ack;
    logic l2_ack;
    logic [1:0] l1_type;

    assign l1_ack = (state_q == sltw_pkg::SLTW_L1) && MEM_ACK;
    assign l2_ack = (state_q == sltw_pkg::SLTW_L2) && MEM_ACK;
    assign l1_type = MEM_RDATA[sltw_pkg::TYPE_HI:sltw_pkg::TYPE_LO];

    // Coarse: 256 words of 4KB each; fine: 1024 words of 1KB each
    always_comb begin
        if (l1_type == sltw_pkg::L1_COARSE) begin
            l2_addr_d = {MEM_RDATA[31:sltw_pkg::COARSE_BASE_LO],
                         va_q[sltw_pkg::L2_IDX_HI:sltw_pkg::COARSE_IDX_LO], 2'h0};
        end else begin
            l2_addr_d = {MEM_RDATA[31:sltw_pkg::FINE_BASE_LO],
                         va_q[sltw_pkg::L2_IDX_HI:sltw_pkg::FINE_IDX_LO], 2'h0};
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q <= sltw_pkg::SLTW_IDLE;
        end else begin
            case (state_q)
                sltw_pkg::SLTW_IDLE: begin
                    if (WALK_REQ) begin
                        state_q <= sltw_pkg::SLTW_L1;
                    end
                end
                sltw_pkg::SLTW_L1: begin
                    if (MEM_ACK) begin
                        if (l1_type == sltw_pkg::L1_COARSE || l1_type == sltw_pkg::L1_FINE) begin
                            state_q <= sltw_pkg::SLTW_L2;
                        end else begin
                            state_q <= sltw_pkg::SLTW_IDLE;
                        end
                    end
                end
                sltw_pkg::SLTW_L2: begin
                    if (MEM_ACK) begin
                        state_q <= sltw_pkg::SLTW_IDLE;
                    end
                end
                default: state_q <= sltw_pkg::SLTW_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            va_q <= sltw_pkg::ADDR_RESET;
            l1_desc_q <= sltw_pkg::ADDR_RESET;
        end else begin
            if (state_q == sltw_pkg::SLTW_IDLE && WALK_REQ) begin
                va_q <= MODIFIED_VIRTUAL_ADDRESS;
            end
            if (l1_ack) begin
                l1_desc_q <= MEM_RDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory fetch port; request held until acknowledged
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            MEM_REQ <= 1'b0;
            MEM_ADDR <= sltw_pkg::ADDR_RESET;
        end else begin
            if (state_q == sltw_pkg::SLTW_IDLE && WALK_REQ) begin
                MEM_REQ <= 1'b1;
                MEM_ADDR <= {TRANSLATION_TABLE_BASE[31:sltw_pkg::TTB_LO],
                             MODIFIED_VIRTUAL_ADDRESS[31:sltw_pkg::L1_IDX_LO], 2'h0};
            end else if (l1_ack && (l1_type == sltw_pkg::L1_COARSE || l1_type == sltw_pkg::L1_FINE)) begin
                MEM_REQ <= 1'b1;
                MEM_ADDR <= l2_addr_d;
            end else if (MEM_ACK) begin
                MEM_REQ <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            WALK_BUSY <= 1'b0;
        end else begin
            WALK_BUSY <= (state_q == sltw_pkg::SLTW_IDLE) ? WALK_REQ
                       : !(l2_ack || (l1_ack && !(l1_type == sltw_pkg::L1_COARSE
                                                   || l1_type == sltw_pkg::L1_FINE)));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            WALK_DONE <= 1'b0;
            WALK_RESULT <= '0;
        end else begin
            WALK_DONE <= 1'b0;
            if (l1_ack && l1_type == sltw_pkg::L1_INVALID) begin
                WALK_DONE <= 1'b1;
                WALK_RESULT <= '0;
                WALK_RESULT.section_fault <= 1'b1;
            end else if (l1_ack && l1_type == sltw_pkg::L1_SECTION) begin
                // Sections are resolved elsewhere; only the type and domain are reported
                WALK_DONE <= 1'b1;
                WALK_RESULT <= '0;
                WALK_RESULT.section_desc <= 1'b1;
                WALK_RESULT.domain <= MEM_RDATA[sltw_pkg::DOM_HI:sltw_pkg::DOM_LO];
            end else if (l2_ack) begin
                WALK_DONE <= 1'b1;
                WALK_RESULT <= l2_decode(MEM_RDATA, va_q,
                                         l1_desc_q[sltw_pkg::DOM_HI:sltw_pkg::DOM_LO]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb_main @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_l1_fetch_addr: assert property (
        (state_q == sltw_pkg::SLTW_IDLE && WALK_REQ) |=> MEM_REQ
            && MEM_ADDR == {$past(TRANSLATION_TABLE_BASE[31:14]), $past(MODIFIED_VIRTUAL_ADDRESS[31:20]), 2'h0})
        else $error("first-level fetch address wrong");

    a_l2_fetch_start: assert property (
        (l1_ack && MEM_RDATA[0]) |=> (state_q == sltw_pkg::SLTW_L2) && MEM_REQ && !WALK_DONE)
        else $error("second-level fetch not started");

    a_coarse_l2_addr: assert property (
        (l1_ack && l1_type == 2'h1) |=> MEM_ADDR == {$past(MEM_RDATA[31:10]), va_q[19:12], 2'h0})
        else $error("coarse second-level address wrong");

    a_fine_l2_addr: assert property (
        (l1_ack && l1_type == 2'h3) |=> MEM_ADDR == {$past(MEM_RDATA[31:12]), va_q[19:10], 2'h0})
        else $error("fine second-level address wrong");

    a_section_fault_out: assert property (
        (l1_ack && l1_type == 2'h0) |=> WALK_DONE && WALK_RESULT.section_fault && !WALK_BUSY
            ##1 !WALK_DONE)
        else $error("section fault not reported");

    a_page_fault_out: assert property (
        (l2_ack && MEM_RDATA[1:0] == 2'h0) |=> WALK_DONE && WALK_RESULT.page_fault
            && WALK_RESULT.size == sltw_pkg::SLTW_SZ_NONE)
        else $error("page fault not reported");

    a_domain_carry: assert property (
        l2_ack |=> WALK_RESULT.domain == l1_desc_q[8:5] && !WALK_RESULT.section_fault)
        else $error("domain not taken from first-level descriptor");

    a_large_phys: assert property (
        (l2_ack && MEM_RDATA[1:0] == 2'h1) |=> WALK_RESULT.phys_addr == {$past(MEM_RDATA[31:16]), va_q[15:0]}
            && WALK_RESULT.access_permission_field == $past(MEM_RDATA[11:4]))
        else $error("large page translation wrong");

    a_small_phys: assert property (
        (l2_ack && MEM_RDATA[1:0] == 2'h2) |=> WALK_RESULT.phys_addr == {$past(MEM_RDATA[31:12]), va_q[11:0]}
            && WALK_RESULT.size == sltw_pkg::SLTW_SZ_SMALL)
        else $error("small page translation wrong");

    a_tiny_perm: assert property (
        (l2_ack && MEM_RDATA[1:0] == 2'h3) |=> WALK_RESULT.access_permission_field == {4{$past(MEM_RDATA[5:4])}}
            && WALK_RESULT.phys_addr == {$past(MEM_RDATA[31:10]), va_q[9:0]})
        else $error("tiny page permissions wrong");

    a_cache_policy: assert property (
        (l2_ack && MEM_RDATA[1:0] != 2'h0) |=> WALK_RESULT.policy == $past(MEM_RDATA[3:2]))
        else $error("cacheability not decoded");

    c_coarse_small: cover property (
        (l1_ack && l1_type == 2'h1) ##[1:20] (l2_ack && MEM_RDATA[1:0] == 2'h2));
    c_fine_tiny: cover property (
        (l1_ack && l1_type == 2'h3) ##[1:20] (l2_ack && MEM_RDATA[1:0] == 2'h3));
    c_section_fault: cover property (l1_ack && l1_type == 2'h0);
    c_back_to_back: cover property (WALK_DONE && WALK_REQ);

endmodule : sltw_walk

`default_nettype wire

// [test/sltw_mem_model.sv]
// Memory model holding translation tables that software has built
`timescale 1ns/10ps
`default_nettype none

module sltw_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] dly,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] tbl [logic [31:0]];
    logic [3:0] wait_q;

    ////////////////////////////////////////////////////////////////////////////
    // Data line toggles outside an ack so a stale word never passes for a fresh one
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            wait_q <= 4'h0;
        end else if (mem_req && !mem_ack && wait_q == dly) begin
            mem_ack <= 1'b1;
            mem_rdata <= tbl.exists(mem_addr) ? tbl[mem_addr] : ~mem_addr;
            wait_q <= 4'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule : sltw_mem_model

`default_nettype wire

// [test/test_second_level_table_walk.sv]
// Self-checking bench for the second-level table walk
`timescale 1ns/10ps
`default_nettype none

module test_second_level_table_walk;
    logic sys_clk;
    logic rst;
    logic walk_req;
    logic [31:0] va;
    logic [31:0] ttb;
    logic mem_ack;
    logic [31:0] mem_rdata;
    logic walk_busy;
    logic mem_req;
    logic [31:0] mem_addr;
    logic walk_done;
    sltw_pkg::sltw_result_t res;
    logic [3:0] dly;
    logic [31:0] aq [$];
    int err_total;
    int check_count;
    int cycles;
    localparam logic [31:0] TTB = 32'h0010_0000;

    sltw_walk dut (.SYS_CLK(sys_clk), .RST(rst), .WALK_REQ(walk_req), .MODIFIED_VIRTUAL_ADDRESS(va),
        .TRANSLATION_TABLE_BASE(ttb), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .WALK_BUSY(walk_busy),
        .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .WALK_DONE(walk_done), .WALK_RESULT(res));
    sltw_mem_model mem (.clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr), .dly(dly),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (mem_req && mem_ack) aq.push_back(mem_addr);
        if (cycles == 3000) begin
            err_total = err_total + 1;
            close_out();
        end
    end

    task automatic close_out();
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    ////////////////////////////////////////////////////////////////////////////
    // Called in the done cycle of the previous walk, so walks run back to back
    task automatic walk(input logic [31:0] v, input logic [31:0] l1, input logic [31:0] l2, input logic [3:0] d);
        logic [31:0] a1;
        logic [31:0] a2;
        int n;
        sltw_pkg::sltw_result_t e;
        a1 = {TTB[31:14], v[31:20], 2'h0};
        a2 = (l1[1:0] == sltw_pkg::L1_COARSE) ? {l1[31:10], v[19:12], 2'h0} : {l1[31:12], v[19:10], 2'h0};
        n = (l2[1:0] == 2'h1) ? ((l1[1:0] == 2'h1) ? 16 : 64) : ((l2[1:0] == 2'h2 && l1[1:0] == 2'h3) ? 4 : 1);
        mem.tbl[a1] = l1;
        if (l1[0]) for (int i = 0; i < n; i++) mem.tbl[(a2 & ~(4 * n - 1)) + 4 * i] = l2;
        e = '0;
        if (l1[1:0] == 2'h0) e.section_fault = 1'b1;
        else e.domain = l1[8:5];
        e.section_desc = (l1[1:0] == 2'h2);
        if (l1[0]) begin
            e.size = sltw_pkg::sltw_size_t'(l2[1:0]);
            e.page_fault = (l2[1:0] == 2'h0);
            if (l2[1:0] != 2'h0) e.policy = sltw_pkg::sltw_policy_t'(l2[3:2]);
            case (l2[1:0])
                2'h1: e.phys_addr = {l2[31:16], v[15:0]};
                2'h2: e.phys_addr = {l2[31:12], v[11:0]};
                2'h3: e.phys_addr = {l2[31:10], v[9:0]};
                default: e.phys_addr = 32'h0;
            endcase
            e.access_permission_field = (l2[1:0] == 2'h3) ? {4{l2[5:4]}} :
                (l2[1:0] == 2'h0 ? 8'h0 : l2[11:4]);
        end
        aq.delete();
        dly = d;
        va = v;
        ttb = TTB;
        walk_req = 1'b1;
        @(posedge sys_clk);
        #1 walk_req = 1'b0;
        check("busy and fetch in walk", 64'h3, {walk_busy, mem_req});
        for (int k = 0; k < 200 && walk_done !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
        check("walk done", 64'h1, walk_done);
        check("busy and fetch after walk", 64'h0, {walk_busy, mem_req});
        check("walk result", e, res);
        check("fetch count", l1[0] ? 2 : 1, aq.size());
        if (aq.size() > 0) check("first fetch address", a1, aq[0]);
        if (l1[0] && aq.size() > 1) check("second fetch address", a2, aq[1]);
    endtask : walk

    ////////////////////////////////////////////////////////////////////////////
    // Table descriptors keep type, bit 4 one and the zero bits
    task automatic t_coarse_pages();
        walk(32'h0120_5ABC, 32'h0012_34B1, 32'h1234_5C6A, 4'h0);
        walk(32'h0130_F123, 32'h0012_34B1, 32'hABCD_0A5D, 4'h2);
    endtask : t_coarse_pages

    task automatic t_fine_pages();
        walk(32'h0140_7F77, 32'h0045_6153, 32'h8765_4C2B, 4'h1);
        walk(32'h0150_3E01, 32'h0045_6153, 32'h0F0F_0336, 4'h0);
        walk(32'h0160_CDEF, 32'h0078_91F3, 32'h7777_0FF1, 4'h3);
    endtask : t_fine_pages

    task automatic t_faults();
        walk(32'h0170_0000, 32'hDEAD_BEEC, 32'h0, 4'h0);
        walk(32'h0180_0000, 32'hFFF0_0DE2, 32'h0, 4'h1);
        walk(32'h0190_1234, 32'h0012_34B1, 32'hFFFF_FFFC, 4'h0);
    endtask : t_faults

    // Reset in mid-fetch must drop the request and leave no stale completion
    task automatic t_reset_mid();
        dly = 4'h8;
        va = 32'h0FF0_0000;
        walk_req = 1'b1;
        @(posedge sys_clk);
        #1 walk_req = 1'b0;
        @(posedge sys_clk);
        #1 rst = 1'b1;
        #1 check("outputs in reset", 64'h0, {walk_busy, mem_req, walk_done});
        check("result in reset", 64'h0, res);
        check("fetch address in reset", 64'h0, mem_addr);
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        walk(32'h0120_5ABC, 32'h0012_34B1, 32'h1234_5C6A, 4'h0);
    endtask : t_reset_mid

    initial begin
        rst = 1'b1;
        walk_req = 1'b0;
        va = 32'h0;
        ttb = 32'h0;
        dly = 4'h0;
        cycles = 0;
        err_total = 0;
        check_count = 0;
        repeat (4) @(posedge sys_clk);
        #1 rst = 1'b0;
        t_coarse_pages();
        t_fine_pages();
        t_faults();
        t_reset_mid();
        close_out();
    end
endmodule : test_second_level_table_walk

`default_nettype wire
